// ---- hdl/fbcl_loader.sv ----
// Configuration loader: flash master, passive and JTAG intake, config RAM
`timescale 1ns/1ps
`default_nettype none

module fbcl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
        $error("fbcl_fifo: DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    wire logic isFull = (wrPtr[AW] != rdPtr[AW]) &&
        (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    wire logic isEmpty = (wrPtr == rdPtr);
    wire logic doWrite = inValid && !isFull;
    wire logic doRead = outReady && !isEmpty;
    assign inReady = !isFull;
    assign outValid = !isEmpty;
    assign outData = mem[rdPtr[AW-1:0]];
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= wrPtr + (AW+1)'(doWrite);
            rdPtr <= rdPtr + (AW+1)'(doRead);
        end
    end
endmodule

module fbcl_loader
    import fbcl_pkg::*;
#(
    parameter int BITSTREAM_BYTES = DEF_BITSTREAM_BYTES,
    parameter int FIFO_DEPTH = DEF_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic configResetN,
    input wire logic [1:0] modeSel,
    output fbcl_flash_t flashOut,
    input wire logic flashMiso,
    input wire logic slaveClk,
    input wire logic slaveCsN,
    input wire logic slaveData,
    input wire logic jtagTck,
    input wire logic jtagLoad,
    input wire logic jtagTdi,
    output logic configDone,
    output logic userMode,
    output logic cramWe,
    output logic [15:0] cramAddr,
    output logic [7:0] cramData
);
    // Byte counters are 16 bits wide, so 65536 would wrap to zero
    if (BITSTREAM_BYTES < 1 || BITSTREAM_BYTES > 65535) begin : gBadLen
        $error("fbcl_loader: BITSTREAM_BYTES out of range");
    end

    // Two-flop synchronisers for all pin inputs
    localparam int NSYNC = 8;
    wire logic [NSYNC-1:0] rawIn = {configResetN, flashMiso, slaveClk,
        slaveCsN, slaveData, jtagTck, jtagLoad, jtagTdi};
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic [NSYNC-1:0] syncC;
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA <= 8'hFF;
            syncB <= 8'hFF;
            syncC <= 8'hFF;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end
    wire logic rstN = syncB[7];
    wire logic rstRise = syncB[7] && !syncC[7];
    wire logic miso = syncB[6];
    wire logic sClkRise = syncB[5] && !syncC[5];
    wire logic sSel = !syncB[4];
    wire logic sDat = syncB[3];
    wire logic tckRise = syncB[2] && !syncC[2];
    wire logic tLoad = syncB[1];
    wire logic tDat = syncB[0];

    // Mode strap is a pin too; its second stage lines up with rstRise
    logic [1:0] modeA;
    logic [1:0] modeB;
    always_ff @(posedge clk) begin
        if (srst) begin
            modeA <= MODE_ACTIVE;
            modeB <= MODE_ACTIVE;
        end else begin
            modeA <= modeSel;
            modeB <= modeA;
        end
    end

    fbcl_state_t state;
    fbcl_state_t next_state;
    logic [1:0] mode;
    logic [15:0] waitCnt;
    logic [5:0] bitCnt;
    logic [39:0] shiftOut;
    logic sclk;
    logic csN;
    logic [7:0] rxShift;
    logic [2:0] rxBits;
    logic [15:0] fetched;
    logic [15:0] written;
    logic fifoInReady;
    logic fifoOutValid;
    logic [7:0] fifoOutData;

    // Bit capture sources per mode
    wire logic flashBit = (state == ST_READ) && sclk && bitCnt == 6'h00;
    wire logic slaveBit = (state == ST_SLAVE) && mode == MODE_PASSIVE &&
        sSel && sClkRise;
    wire logic jtagBit = (state == ST_SLAVE) && mode == MODE_JTAG &&
        tLoad && tckRise;
    wire logic slaveIn = (mode == MODE_JTAG) ? tDat : sDat;
    wire logic rxBitIn = (state == ST_READ) ? miso : slaveIn;
    wire logic rxTake = flashBit || slaveBit || jtagBit;
    wire logic byteDone = rxTake && rxBits == 3'h7;
    wire logic allFetched = fetched == 16'(BITSTREAM_BYTES);
    wire logic allWritten = written == 16'(BITSTREAM_BYTES);
    // Flash clock pauses low while the buffer is full; high would resample
    wire logic flashStep = (state == ST_WAKE || state == ST_CMD) ||
        (state == ST_READ && (fifoInReady || sclk));
    wire logic phaseEnd = sclk && bitCnt == 6'h00;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (rstRise) begin
                    next_state = (modeB == MODE_ACTIVE) ? ST_WAKE : ST_SLAVE;
                end
            end
            ST_WAKE: begin
                if (phaseEnd) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (waitCnt == 16'(WAKE_WAIT_CYC - 1)) begin
                    next_state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (phaseEnd) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (allFetched && allWritten) begin
                    next_state = ST_DONE;
                end
            end
            ST_SLAVE: begin
                if (allWritten) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_IDLE;
        endcase
        if (!rstN) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            mode <= MODE_ACTIVE;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && rstRise) begin
                mode <= modeB;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state != ST_WAIT) begin
            waitCnt <= '0;
        end else begin
            waitCnt <= waitCnt + 16'h0001;
        end
    end

    // Serial clock is half the system clock; data changes on falling edge
    always_ff @(posedge clk) begin
        if (srst || next_state == ST_IDLE || next_state == ST_WAIT ||
            next_state == ST_SLAVE || next_state == ST_DONE) begin
            sclk <= 1'b0;
            csN <= 1'b1;
            bitCnt <= '0;
            shiftOut <= '0;
        end else if (state != next_state) begin
            csN <= 1'b0;
            sclk <= 1'b0;
            if (next_state == ST_WAKE) begin
                shiftOut <= {CMD_WAKE, 32'h0};
                bitCnt <= 6'h07;
            end else if (next_state == ST_CMD) begin
                // Instruction, zero address, dummy byte
                shiftOut <= {CMD_FAST_READ, START_ADDR, 8'h00};
                bitCnt <= 6'(8 + 24 + DUMMY_BITS - 1);
            end
        end else if (flashStep && !(state == ST_READ && allFetched)) begin
            sclk <= !sclk;
            if (sclk) begin
                shiftOut <= {shiftOut[38:0], 1'b0};
                if (bitCnt != 6'h00) begin
                    bitCnt <= bitCnt - 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state == ST_IDLE) begin
            rxShift <= '0;
            rxBits <= '0;
            fetched <= '0;
        end else if (rxTake && !allFetched) begin
            rxShift <= {rxShift[6:0], rxBitIn};
            rxBits <= rxBits + 3'h1;
            if (byteDone) begin
                fetched <= fetched + 16'h0001;
            end
        end
    end

    // Capture happens on the rising serial edge; flash mode takes one bit per pair of clocks
    wire logic [7:0] newByte = {rxShift[6:0], rxBitIn};
    logic pushValid;
    logic [7:0] pushData;
    always_ff @(posedge clk) begin
        if (srst || state == ST_IDLE) begin
            pushValid <= 1'b0;
            pushData <= '0;
        end else begin
            pushValid <= byteDone && !allFetched;
            pushData <= newByte;
        end
    end

    // Passive sources cannot be stalled; flash source is stalled above
    fbcl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uFifo (
        .clk(clk),
        .srst(srst || state == ST_IDLE),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(pushData),
        .outValid(fifoOutValid),
        .outReady(1'b1),
        .outData(fifoOutData)
    );

    always_ff @(posedge clk) begin
        if (srst || state == ST_IDLE) begin
            written <= '0;
            cramWe <= 1'b0;
            cramAddr <= '0;
            cramData <= '0;
        end else begin
            cramWe <= fifoOutValid;
            if (fifoOutValid) begin
                cramAddr <= written;
                cramData <= fifoOutData;
                written <= written + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            configDone <= 1'b0;
            userMode <= 1'b0;
            flashOut <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
        end else begin
            // Last write lands in config_ram one cycle after counter completes
            configDone <= (state == ST_DONE) && !cramWe;
            userMode <= (state == ST_DONE) && !cramWe;
            flashOut <= '{sclk: sclk, csN: csN, mosi: shiftOut[39]};
        end
    end
endmodule
`default_nettype wire

// ---- shared/fbcl_pkg.sv ----
// Shared constants and types for the configuration loader
package fbcl_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int WAKE_WAIT_US = 30;
    // Least time rounds up to whole cycles
    localparam int WAKE_WAIT_CYC = (WAKE_WAIT_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [23:0] START_ADDR = 24'h000000;
    localparam int DUMMY_BITS = 8;
    localparam int DEF_BITSTREAM_BYTES = 16;
    localparam int DEF_FIFO_DEPTH = 8;
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_PASSIVE = 2'h1;
    localparam logic [1:0] MODE_JTAG = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_WAKE = 7'b0000010,
        ST_WAIT = 7'b0000100,
        ST_CMD = 7'b0001000,
        ST_READ = 7'b0010000,
        ST_SLAVE = 7'b0100000,
        ST_DONE = 7'b1000000
    } fbcl_state_t;

    // Flash pins driven by the loader
    typedef struct packed {
        logic sclk;
        logic csN;
        logic mosi;
    } fbcl_flash_t;
endpackage

// ---- test/fbcl_flash_model.sv ----
// Serial flash partner answering wake and fast read
`timescale 1ns/1ps
`default_nettype none
module fbcl_flash_model
    import fbcl_pkg::*;
(
    input wire fbcl_flash_t pins,
    output logic miso,
    output logic protoErr
);
    logic [31:0] rx;
    logic [7:0] b;
    logic woke;
    int n;
    int k;
    realtime tUp;
    initial begin
        miso = 1'b0;
        protoErr = 1'b0;
        woke = 1'b0;
        rx = '0;
        tUp = 0.0;
        forever begin
            @(negedge pins.csN);
            if (woke && $realtime - tUp < 30000.0) protoErr = 1'b1;
            n = 0;
            while (pins.csN === 1'b0) begin
                @(posedge pins.sclk or posedge pins.csN);
                if (pins.csN === 1'b0) begin
                    rx = {rx[30:0], pins.mosi};
                    n++;
                    if (n == 8 && rx[7:0] === CMD_WAKE) woke = 1'b1;
                    if (n == 32 && (!woke || rx !== {CMD_FAST_READ,
                        START_ADDR})) protoErr = 1'b1;
                    // Data leads by one serial clock: the loader samples
                    // through its input sync, one serial period late
                    if (n >= 39) begin
                        k = n - 39;
                        b = 8'hC5 ^ 8'(k / 8);
                        miso = b[7 - k % 8];
                    end
                end
            end
            if (n == 8) tUp = $realtime;
            // A finished read needs a fresh wake before the next one
            if (n >= 40) woke = 1'b0;
            // Released line floats: show the inverse, not the last bit
            miso = ~miso;
        end
    end
endmodule
`default_nettype wire

// ---- test/fbcl_loader_sva.sv ----
// Port checker for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module fbcl_loader_sva
    import fbcl_pkg::*;
#(
    parameter int BITSTREAM_BYTES = DEF_BITSTREAM_BYTES,
    parameter int FIFO_DEPTH = DEF_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic configResetN,
    input wire fbcl_flash_t flashOut,
    input wire logic configDone,
    input wire logic userMode,
    input wire logic cramWe,
    input wire logic [15:0] cramAddr
);
    logic [31:0] sh;
    int frm;
    int bits;
    int gap;
    int wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    always_ff @(posedge clk) begin
        if (srst || !configResetN) begin
            frm <= 0;
            bits <= 0;
            gap <= 0;
            wr <= 0;
        end else begin
            if ($rose(flashOut.csN)) frm <= frm + 1;
            if (flashOut.csN) bits <= 0;
            else if ($rose(flashOut.sclk)) bits <= bits + 1;
            gap <= flashOut.csN ? gap + 1 : 0;
            if (cramWe) wr <= wr + 1;
        end
    end
    always_ff @(posedge clk) begin
        if ($rose(flashOut.sclk)) sh <= {sh[30:0], flashOut.mosi};
    end
    a_wake_first: assert property ($rose(flashOut.csN) && configResetN
        && frm == 0 |-> bits == 8 && sh[7:0] == CMD_WAKE)
        else $error("wake frame wrong");
    a_read_cmd: assert property ($rose(flashOut.sclk) && frm == 1
        && bits == 32 |-> sh == {CMD_FAST_READ, START_ADDR})
        else $error("fast read header wrong");
    a_wake_gap: assert property ($fell(flashOut.csN) && frm == 1
        |-> gap >= WAKE_WAIT_CYC) else $error("wake wait too short");
    a_sclk_pairs: assert property ($rose(flashOut.sclk)
        |=> !flashOut.sclk) else $error("sclk rate wrong");
    a_done_count: assert property ($rose(configDone)
        |-> wr + cramWe == BITSTREAM_BYTES) else $error("early done");
    a_no_write_done: assert property (configDone |-> !cramWe)
        else $error("write after done");
    a_user_done: assert property (userMode == configDone)
        else $error("user mode apart from done");
    a_addr_pair: assert property (cramWe |-> cramAddr == 16'(wr)
        && wr < BITSTREAM_BYTES) else $error("write address wrong");
    a_idle_reset: assert property ((!configResetN) [*6]
        |-> flashOut.csN && !configDone) else $error("not idle in reset");
    c_done: cover property ($rose(configDone));
    c_read: cover property ($fell(flashOut.csN) && frm == 1);
    c_write: cover property (cramWe);
endmodule
bind fbcl_loader fbcl_loader_sva #(
    .BITSTREAM_BYTES(BITSTREAM_BYTES),
    .FIFO_DEPTH(FIFO_DEPTH)
) chk (.clk(clk), .srst(srst), .configResetN(configResetN),
    .flashOut(flashOut), .configDone(configDone), .userMode(userMode),
    .cramWe(cramWe), .cramAddr(cramAddr));
`default_nettype wire

// ---- test/fbcl_loader_tb.sv ----
// Testbench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module fbcl_loader_tb;
    import fbcl_pkg::*;
    localparam int NB = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic configResetN = 1'b0;
    logic [1:0] modeSel = MODE_ACTIVE;
    logic sClk = 1'b0, sCsN = 1'b1, sDat = 1'b0;
    logic tck = 1'b0, tLoad = 1'b0, tdi = 1'b0;
    fbcl_flash_t flashOut;
    logic miso, protoErr, configDone, userMode, cramWe;
    logic [15:0] cramAddr;
    logic [7:0] cramData;
    logic [7:0] mem [256];
    int wrN;
    int error_cnt = 0;
    int n_compared = 0;
    always #20 clk = ~clk;
    fbcl_loader #(.BITSTREAM_BYTES(NB)) dut (.clk(clk), .srst(srst),
        .configResetN(configResetN), .modeSel(modeSel),
        .flashOut(flashOut), .flashMiso(miso), .slaveClk(sClk),
        .slaveCsN(sCsN), .slaveData(sDat), .jtagTck(tck),
        .jtagLoad(tLoad), .jtagTdi(tdi), .configDone(configDone),
        .userMode(userMode), .cramWe(cramWe), .cramAddr(cramAddr),
        .cramData(cramData));
    fbcl_flash_model flash (.pins(flashOut), .miso(miso),
        .protoErr(protoErr));
    // Capture is cleared while the host holds the config reset low
    always @(posedge clk) begin
        if (!configResetN) begin
            foreach (mem[i]) mem[i] <= 8'h00;
            wrN <= 0;
        end else if (cramWe) begin
            mem[cramAddr[7:0]] <= cramData;
            wrN <= wrN + 1;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic start(input logic [1:0] m);
        configResetN = 1'b0;
        modeSel = m;
        cyc(8);
        check(configDone, 1'b0);
        configResetN = 1'b1;
    endtask
    task automatic wait_done(input int lim);
        int i;
        for (i = 0; i < lim && configDone !== 1'b1; i++) cyc(1);
        if (configDone !== 1'b1) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic check_mem(input logic [7:0] base);
        for (int i = 0; i < NB; i++) check(mem[i], base ^ 8'(i));
        check(16'(wrN), 16'(NB));
        check(userMode, 1'b1);
    endtask
    // Each edge lasts 8 clocks, the slowest rate the intake promises
    task automatic send_byte(input logic [7:0] v, input logic jt);
        for (int i = 7; i >= 0; i--) begin
            if (jt) tdi = v[i];
            else sDat = v[i];
            cyc(8);
            if (jt) tck = 1'b1;
            else sClk = 1'b1;
            cyc(8);
            tck = 1'b0;
            sClk = 1'b0;
        end
    endtask
    task automatic t_active();
        start(MODE_ACTIVE);
        cyc(300);
        check(configDone, 1'b0);
        wait_done(4000);
        check_mem(8'hC5);
        check(protoErr, 1'b0);
        $display("test active done");
    endtask
    task automatic t_passive();
        start(MODE_PASSIVE);
        sCsN = 1'b0;
        for (int i = 0; i < NB - 1; i++) send_byte(8'h3C ^ 8'(i), 1'b0);
        cyc(20);
        check(configDone, 1'b0);
        send_byte(8'h3C ^ 8'(NB - 1), 1'b0);
        wait_done(200);
        send_byte(8'hFF, 1'b0);
        cyc(20);
        check_mem(8'h3C);
        check(flashOut.csN, 1'b1);
        sCsN = 1'b1;
        $display("test passive done");
    endtask
    task automatic t_jtag();
        start(MODE_JTAG);
        tLoad = 1'b1;
        for (int i = 0; i < NB; i++) send_byte(8'h96 ^ 8'(i), 1'b1);
        wait_done(200);
        check_mem(8'h96);
        tLoad = 1'b0;
        $display("test jtag done");
    endtask
    initial begin
        cyc(16);
        srst = 1'b0;
        t_active();
        t_passive();
        t_jtag();
        t_active();
        tally_and_finish();
    end
endmodule
`default_nettype wire
